// ===== hw/asc_cfg.svh
// offsets, field positions, reset values and counts of the audio serial config block
// assumes an 8-bit register address and 16-bit register data
`ifndef ASC_CFG_SVH
`define ASC_CFG_SVH

// register offsets
`define ASC_CFG_OFS     8'h1c
`define ASC_PRESC_OFS   8'h20
`define ASC_STAT_OFS    8'h24

// reset values
`define ASC_CFG_RST     16'h0000
`define ASC_PRESC_RST   16'h0002

// configuration register fields
`define ASC_PSEL_BIT    11
`define ASC_EN_BIT      10
`define ASC_ROLE_HI     9
`define ASC_ROLE_LO     8
`define ASC_PCMS_BIT    7
`define ASC_STD_HI      5
`define ASC_STD_LO      4
`define ASC_IDLE_BIT    3
`define ASC_SLEN_HI     2
`define ASC_SLEN_LO     1
`define ASC_CHW_BIT     0

// prescaler register fields
`define ASC_MCO_BIT     9
`define ASC_ODD_BIT     8
`define ASC_LINEAR_DIVIDER_HI     7
`define ASC_LINEAR_DIVIDER_LO     0

// encodings
`define ASC_STD_I2S     2'h0
`define ASC_STD_PCM     2'h3
`define ASC_SLEN_16     2'h0
`define ASC_SLEN_BAD    2'h3

// counts in serial clock periods or mclk cycles
`define ASC_CH16_LAST   6'h0f
`define ASC_CH32_LAST   6'h1f
`define ASC_SYNC_SHORT  6'h01
`define ASC_SYNC_LONG   6'h0d
`define ASC_DIV_MIN     9'h004

`endif

// ===== hw/asc_clock_div.sv
// prescaler: one tick every (2*divider + odd) clock cycles, at least 4, while enabled
// assumes a synchronous active-low reset already released cleanly
`timescale 1ns/1ps
`default_nettype none
`include "asc_cfg.svh"

module asc_clock_div (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rstSync_n,
	// control
	input  wire logic       run,
	input  wire logic [7:0] linearDivider,
	input  wire logic       oddFactor,
	// output
	output var  logic       tick
);

	asc_pkg::asc_div_state_t st;
	asc_pkg::asc_div_state_t nx;
	logic [8:0]              divFactor;

	// division factor; forbidden small values clamp so the count never wraps
	always_comb begin
		divFactor = {linearDivider, 1'b0} + {8'h00, oddFactor};
		if (divFactor < `ASC_DIV_MIN) begin
			divFactor = `ASC_DIV_MIN;
		end
	end

	// counter runs only for a master, so a slave sees no ticks
	always_comb begin
		nx = st;
		nx.tick = 1'b0;
		if (!run) begin
			nx.cnt = 9'h000;
		end else if (st.cnt >= divFactor - 9'h001) begin
			nx.cnt  = 9'h000;
			nx.tick = 1'b1;
		end else begin
			nx.cnt = st.cnt + 9'h001;
		end
	end

	always_ff @(posedge clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			st <= '0;
		end else begin
			st <= nx;
		end
	end

	assign tick = st.tick;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstSync_n);

	a_tick_on_wrap: assert property (
		(run && st.cnt == divFactor - 9'h001) |=> tick)
		else $error("divider missed its wrap tick");
	a_tick_only_wrap: assert property (
		(run && st.cnt < divFactor - 9'h001) |=> !tick)
		else $error("divider ticked early");
	a_no_tick_idle: assert property (
		(!run) |=> !tick ##0 st.cnt == 9'h000)
		else $error("divider ticked while stopped");

endmodule // asc_clock_div

`default_nettype wire

// ===== hw/asc_mode_config.sv
// audio serial mode configuration, prescaler and clock/word-select engine
// assumes synchronous pins and a master that never waits on the register port
`timescale 1ns/1ps
`default_nettype none
`include "asc_cfg.svh"

module asc_mode_config (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_n,
	// register port
	input  wire logic [7:0]  regAddr,
	input  wire logic [15:0] regWrData,
	input  wire logic        regWrStb,
	input  wire logic        regRdStb,
	output var  logic [15:0] regRdData,
	// serial clock pin
	input  wire logic        sckIn,
	output var  logic        sckOut,
	output var  logic        sckOe_n,
	// word select pin
	input  wire logic        wsIn,
	output var  logic        wsOut,
	output var  logic        wsOe_n,
	// master clock pin
	output var  logic        mclkOut,
	// status
	output var  logic        audioRunning,
	output var  logic        channelSide,
	output var  logic        transmitDir
);

	logic                    rstMeta_n;
	logic                    rstSync_n;
	asc_pkg::asc_top_state_t st;
	asc_pkg::asc_top_state_t nx;
	logic                    divTick;
	logic                    runReq;
	logic                    isMaster;
	logic                    effChw;
	logic [5:0]              lastBit;
	logic [5:0]              syncLen;
	logic                    cfgWr;
	logic                    prescWr;

	// reset released through two flops, asserted at once
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rstMeta_n <= 1'b0;
			rstSync_n <= 1'b0;
		end else begin
			rstMeta_n <= 1'b1;
			rstSync_n <= rstMeta_n;
		end
	end

	// decoded conditions
	assign cfgWr    = regWrStb && (regAddr == `ASC_CFG_OFS);
	assign prescWr  = regWrStb && (regAddr == `ASC_PRESC_OFS);
	assign runReq   = st.en && st.psel;
	assign isMaster = st.role[1];
	assign effChw   = (st.slen != `ASC_SLEN_16) || st.chw;
	assign lastBit  = effChw ? `ASC_CH32_LAST : `ASC_CH16_LAST;
	assign syncLen  = st.pcmLong ? `ASC_SYNC_LONG : `ASC_SYNC_SHORT;

	// prescaler only counts for a running master
	asc_clock_div u_div (
		.clk           (mclk),
		.rstSync_n     (rstSync_n),
		.run           (st.phase == asc_pkg::ASC_PH_RUN && runReq && isMaster),
		.linearDivider (st.linear_divider),
		.oddFactor     (st.odd),
		.tick          (divTick)
	);

	// next state: register access, then the serial engine
	always_comb begin
		nx = st;
		nx.rdata = 16'h0000;
		nx.txDir = ~st.role[0];

		// configuration write; role and mode only take while disabled
		if (cfgWr) begin
			if (!st.en) begin
				nx.psel = regWrData[`ASC_PSEL_BIT];
				nx.role = regWrData[`ASC_ROLE_HI:`ASC_ROLE_LO];
			end
			nx.en      = regWrData[`ASC_EN_BIT];
			nx.pcmLong = regWrData[`ASC_PCMS_BIT];
			nx.std     = regWrData[`ASC_STD_HI:`ASC_STD_LO];
			nx.idleLvl = regWrData[`ASC_IDLE_BIT];
			nx.chw     = regWrData[`ASC_CHW_BIT];
			// the forbidden length code is dropped, old length kept
			if (regWrData[`ASC_SLEN_HI:`ASC_SLEN_LO] != `ASC_SLEN_BAD) begin
				nx.slen = regWrData[`ASC_SLEN_HI:`ASC_SLEN_LO];
			end
		end

		// prescaler write; taken as written, software keeps it stable while on
		if (prescWr) begin
			nx.mco  = regWrData[`ASC_MCO_BIT];
			nx.odd  = regWrData[`ASC_ODD_BIT];
			nx.linear_divider = regWrData[`ASC_LINEAR_DIVIDER_HI:`ASC_LINEAR_DIVIDER_LO];
		end

		// read data stand one cycle; unmapped reads as zero
		if (regRdStb) begin
			unique case (regAddr)
				`ASC_CFG_OFS: begin
					nx.rdata = {4'h0, st.psel, st.en, st.role, st.pcmLong, 1'b0,
						st.std, st.idleLvl, st.slen, st.chw};
				end
				`ASC_PRESC_OFS: begin
					nx.rdata = {6'h00, st.mco, st.odd, st.linear_divider};
				end
				`ASC_STAT_OFS: begin
					nx.rdata = {13'h0000, effChw, st.side, st.running};
				end
				default: begin
					nx.rdata = 16'h0000;
				end
			endcase
		end

		// serial engine
		unique case (st.phase)
			asc_pkg::ASC_PH_OFF: begin
				nx.sck     = st.idleLvl;
				nx.ws      = 1'b0;
				nx.sckOe_n = 1'b1;
				nx.wsOe_n  = 1'b1;
				nx.mclkOut = 1'b0;
				nx.bitCnt  = 6'h00;
				nx.side    = 1'b0;
				nx.running = 1'b0;
				nx.sckInPrev = st.idleLvl;
				nx.wsInPrev  = wsIn;
				if (runReq) begin
					nx.phase   = asc_pkg::ASC_PH_RUN;
					nx.running = 1'b1;
				end
			end
			asc_pkg::ASC_PH_RUN: begin
				if (!runReq) begin
					// stop: clock parks at idle level, pins released
					nx.phase   = asc_pkg::ASC_PH_OFF;
					nx.running = 1'b0;
					nx.sck     = st.idleLvl;
					nx.ws      = 1'b0;
					nx.sckOe_n = 1'b1;
					nx.wsOe_n  = 1'b1;
					nx.mclkOut = 1'b0;
				end else if (isMaster) begin
					nx.sckOe_n = 1'b0;
					nx.wsOe_n  = 1'b0;
					if (divTick) begin
						nx.sck = ~st.sck;
						nx.mclkOut = ~st.mclkOut;
						// a full period ends when the clock returns to idle
						if (~st.sck == st.idleLvl) begin
							if (st.bitCnt == lastBit) begin
								nx.bitCnt = 6'h00;
								nx.side   = ~st.side;
							end else begin
								nx.bitCnt = st.bitCnt + 6'h01;
							end
						end
					end
					// master clock held low when its output is off
					if (!st.mco) begin
						nx.mclkOut = 1'b0;
					end
					// word select from the position in the frame
					if (st.std == `ASC_STD_PCM) begin
						nx.ws = !nx.side && (nx.bitCnt < syncLen);
					end else if (st.std == `ASC_STD_I2S) begin
						nx.ws = nx.side;
					end else begin
						nx.ws = ~nx.side;
					end
				end else begin
					// slave: pins are inputs, clock comes from outside
					nx.sckOe_n   = 1'b1;
					nx.wsOe_n    = 1'b1;
					nx.mclkOut   = 1'b0;
					nx.sck       = st.idleLvl;
					nx.ws        = 1'b0;
					nx.sckInPrev = sckIn;
					nx.wsInPrev  = wsIn;
					if (st.std == `ASC_STD_PCM) begin
						nx.side = 1'b0;
					end else if (st.std == `ASC_STD_I2S) begin
						nx.side = wsIn;
					end else begin
						nx.side = ~wsIn;
					end
					// bit position restarts on every word select change
					if (wsIn != st.wsInPrev) begin
						nx.bitCnt = 6'h00;
					end else if (sckIn != st.sckInPrev && sckIn == st.idleLvl) begin
						nx.bitCnt = (st.bitCnt == lastBit) ? 6'h00 : st.bitCnt + 6'h01;
					end
				end
			end
		endcase
	end

	// one register for the whole state
	always_ff @(posedge mclk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			st      <= '0;
			st.linear_divider <= 8'(`ASC_PRESC_RST); // divider sits in the low byte
			st.sckOe_n <= 1'b1;
			st.wsOe_n  <= 1'b1;
			st.txDir   <= 1'b1;
		end else begin
			st <= nx;
		end
	end

	// outputs straight from the state register
	assign regRdData    = st.rdata;
	assign sckOut       = st.sck;
	assign sckOe_n      = st.sckOe_n;
	assign wsOut        = st.ws;
	assign wsOe_n       = st.wsOe_n;
	assign mclkOut      = st.mclkOut;
	assign audioRunning = st.running;
	assign channelSide  = st.side;
	assign transmitDir  = st.txDir;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstSync_n);

	a_role_locked: assert property (
		(cfgWr && st.en) |=> $stable(st.role) && $stable(st.psel))
		else $error("role changed while enabled");
	a_bad_len_held: assert property (
		(cfgWr && regWrData[2:1] == 2'h3) |=> $stable(st.slen))
		else $error("forbidden sample length stored");
	a_chan_forced: assert property (
		(regRdStb && regAddr == `ASC_STAT_OFS && st.slen != 2'h0) |=> regRdData[2])
		else $error("channel width not forced to 32");
	a_idle_level: assert property (
		(st.phase == asc_pkg::ASC_PH_OFF) |=> (st.phase == asc_pkg::ASC_PH_RUN)
			|| (sckOut == $past(st.idleLvl)))
		else $error("serial clock not at idle level");
	a_pcm_short: assert property (
		(st.phase == asc_pkg::ASC_PH_RUN && isMaster && !sckOe_n && st.std == 2'h3
			&& !st.pcmLong && st.bitCnt != 6'h00) |-> !wsOut)
		else $error("short frame sync too long");
	a_std_polarity: assert property (
		(st.phase == asc_pkg::ASC_PH_RUN && runReq && isMaster && !wsOe_n
			&& st.std != 2'h3) |-> wsOut == (st.std == 2'h0 ? st.side : ~st.side))
		else $error("word select polarity wrong");
	a_mclk_gate: assert property (
		(!st.mco && !prescWr) |=> !mclkOut [*2])
		else $error("master clock out while disabled");
	a_slave_release: assert property (
		(st.phase == asc_pkg::ASC_PH_RUN && !isMaster) |=> sckOe_n && wsOe_n)
		else $error("slave drives the clock pins");
	a_stop_parks: assert property (
		(st.phase == asc_pkg::ASC_PH_RUN && !runReq) |=> !audioRunning && sckOe_n
			##1 sckOut == $past(st.idleLvl))
		else $error("stop did not park the link");

	// register readback and pin ownership
	a_std_readback: assert property (
		(regRdStb && regAddr == `ASC_CFG_OFS) |=> regRdData[5:4] == $past(st.std))
		else $error("standard field read back wrong");
	a_presc_readback: assert property (
		(regRdStb && regAddr == `ASC_PRESC_OFS) |=> regRdData[9:0]
			== {$past(st.mco), $past(st.odd), $past(st.linear_divider)})
		else $error("prescaler read back wrong");
	a_chan_sixteen: assert property (
		(regRdStb && regAddr == `ASC_STAT_OFS && st.slen == 2'h0 && !st.chw)
			|=> !regRdData[2])
		else $error("channel width not sixteen");
	a_tx_dir: assert property (
		$stable(st.role) |-> transmitDir == ~st.role[0])
		else $error("transmit direction wrong");
	a_spi_idle: assert property (
		(!st.psel) |=> !audioRunning)
		else $error("engine ran in serial peripheral mode");
	a_mode_start: assert property (
		(st.phase == asc_pkg::ASC_PH_OFF && runReq) |=> audioRunning)
		else $error("engine did not start");
	a_off_released: assert property (
		(st.phase == asc_pkg::ASC_PH_OFF) |=> sckOe_n && wsOe_n)
		else $error("pins driven while stopped");

	// master serial clock and frame sync shape
	a_master_drives: assert property (
		(st.phase == asc_pkg::ASC_PH_RUN && runReq && isMaster)
			|=> !sckOe_n && !wsOe_n)
		else $error("master left its pins released");
	a_sck_toggle: assert property (
		(st.phase == asc_pkg::ASC_PH_RUN && runReq && isMaster && divTick)
			|=> sckOut != $past(sckOut))
		else $error("serial clock missed a tick");
	a_sck_steady: assert property (
		(st.phase == asc_pkg::ASC_PH_RUN && runReq && isMaster && !divTick)
			|=> $stable(sckOut))
		else $error("serial clock moved between ticks");
	a_pcm_long: assert property (
		(st.phase == asc_pkg::ASC_PH_RUN && isMaster && !sckOe_n && st.std == 2'h3
			&& st.pcmLong && st.bitCnt >= 6'h0d) |-> !wsOut)
		else $error("long frame sync too long");
	a_pcm_start: assert property (
		(st.phase == asc_pkg::ASC_PH_RUN && isMaster && !sckOe_n && st.std == 2'h3
			&& !st.side && st.bitCnt == 6'h00) |-> wsOut)
		else $error("frame sync missing at frame start");

	// slave keeps its hands off the clock pins
	a_slave_no_mclk: assert property (
		(st.phase == asc_pkg::ASC_PH_RUN && !isMaster) |=> !mclkOut)
		else $error("slave drove the master clock");
	a_slave_idle_sck: assert property (
		(st.phase == asc_pkg::ASC_PH_RUN && !isMaster) |=> sckOut == $past(st.idleLvl))
		else $error("slave serial clock left idle");

	c_master_run: cover property (
		audioRunning && isMaster && $changed(channelSide));
	c_pcm_long: cover property (
		audioRunning && st.std == 2'h3 && st.pcmLong && $fell(wsOut));
	c_slave_side: cover property (
		audioRunning && !isMaster && $changed(channelSide));
	c_mclk_toggle: cover property (
		audioRunning && $rose(mclkOut));
	c_odd_divider: cover property (
		audioRunning && isMaster && st.odd && divTick);

endmodule // asc_mode_config

`default_nettype wire

// ===== hw/asc_pkg.sv
// types shared by the audio serial config block
// assumes nothing beyond a SystemVerilog compiler
package asc_pkg;

	// link phase of the serial engine
	typedef enum logic {
		ASC_PH_OFF,
		ASC_PH_RUN
	} asc_phase_t;

	// whole state of the top module
	typedef struct packed {
		logic        psel;
		logic        en;
		logic [1:0]  role;
		logic        pcmLong;
		logic [1:0]  std;
		logic        idleLvl;
		logic [1:0]  slen;
		logic        chw;
		logic        mco;
		logic        odd;
		logic [7:0]  linear_divider;
		logic [15:0] rdata;
		asc_phase_t  phase;
		logic        sck;
		logic        sckOe_n;
		logic        ws;
		logic        wsOe_n;
		logic        mclkOut;
		logic [5:0]  bitCnt;
		logic        side;
		logic        sckInPrev;
		logic        wsInPrev;
		logic        running;
		logic        txDir;
	} asc_top_state_t;

	// whole state of the clock divider
	typedef struct packed {
		logic [8:0] cnt;
		logic       tick;
	} asc_div_state_t;

endpackage

// ===== verif/asc_codec_model.sv
// far-side audio master model used while the device sits in a slave role
// assumes the bench resolves each shared pin from the device's enable
`timescale 1ns/1ps
`default_nettype none

module asc_codec_model (
	// clock
	input  wire logic mclk,
	// control from the bench
	input  wire logic run,
	// pins toward the device
	output var  logic sck,
	output var  logic ws
);
	int cnt = 0;
	int bits = 0;

	// clock halts while run is low; a released ws flips every cycle so no stale level survives
	always @(posedge mclk) begin
		if (!run) begin
			cnt <= 0;
			bits <= 0;
			sck <= 1'b0;
			ws <= ~ws;
		end else if (cnt == 5) begin
			cnt <= 0;
			sck <= ~sck; // slave clock comes from here
			if (sck)
				bits <= (bits + 1) % 16;
			if (sck && bits == 15)
				ws <= ~ws; // changes on a falling clock, after sixteen bits
		end else begin
			cnt <= cnt + 1;
		end
	end

	// known levels before the first edge
	initial begin
		sck = 1'b0;
		ws = 1'b0;
	end
endmodule // asc_codec_model

`default_nettype wire

// ===== verif/asc_mode_config_bench.sv
// self-checking bench of the audio serial config block with a far-side master
// assumes the design files and asc_codec_model are compiled first
`timescale 1ns/1ps
`default_nettype none

module asc_mode_config_bench;
	logic        mclk = 0;
	logic        rst_n = 0;
	logic [7:0]  regAddr = 0;
	logic [15:0] regWrData = 0;
	logic        regWrStb = 0;
	logic        regRdStb = 0;
	logic [15:0] regRdData;
	logic        sckOut, sckOe_n, wsOut, wsOe_n, mclkOut;
	logic        audioRunning, channelSide, transmitDir;
	logic        pSck, pWs, pRun = 0, wsQ = 0, mq = 0;
	int          mismatches = 0, compares = 0, wsStab = 0, mTog = 0, n;
	int          ldT[3] = '{2, 3, 5}, odT[3] = '{0, 1, 0};
	logic [15:0] cfgM = 16'h0000, preM = 16'h0002, d;
	logic [31:0] lfsr = 32'h9ceaf68b;
	wire         sckLine = sckOe_n ? pSck : sckOut;
	wire         wsLine = wsOe_n ? pWs : wsOut;

	// 200 MHz clock
	initial begin
		forever #2.5 mclk = ~mclk;
	end

	asc_mode_config i_asc_mode_config (.mclk(mclk), .rst_n(rst_n), .regAddr(regAddr),
		.regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
		.regRdData(regRdData), .sckIn(sckLine), .sckOut(sckOut), .sckOe_n(sckOe_n),
		.wsIn(wsLine), .wsOut(wsOut), .wsOe_n(wsOe_n), .mclkOut(mclkOut),
		.audioRunning(audioRunning), .channelSide(channelSide), .transmitDir(transmitDir));
	asc_codec_model i_asc_codec_model (.mclk(mclk), .run(pRun), .sck(pSck), .ws(pWs));

	// word-select stability and master clock activity
	always @(posedge mclk) begin
		wsQ <= wsLine;
		wsStab <= (wsLine === wsQ) ? wsStab + 1 : 0;
		mq <= mclkOut;
		if (mclkOut !== mq)
			mTog <= mTog + 1;
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// one settled clock step; every wait is bounded here
	task automatic step();
		@(posedge mclk);
		#1;
		n++;
		if (n > 3000) begin
			chk(16'h1, 16'h0);
			report_and_stop();
		end
	endtask

	// write with a model update; the trailing edge keeps strobes from colliding
	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		logic [15:0] nv;
		nv = v & 16'h0fbf;
		regAddr <= a;
		regWrData <= v;
		regWrStb <= 1'b1;
		@(posedge mclk);
		regWrStb <= 1'b0;
		if (nv[2:1] == 2'h3)
			nv[2:1] = cfgM[2:1];
		if (cfgM[10])
			{nv[11], nv[9:8]} = {cfgM[11], cfgM[9:8]};
		if (a == 8'h1c)
			cfgM = nv;
		if (a == 8'h20)
			preM = v & 16'h03ff;
		@(posedge mclk);
	endtask

	// read; a zero mask only fetches into d
	task automatic rd(input logic [7:0] a, input logic [15:0] mask);
		regAddr <= a;
		regRdStb <= 1'b1;
		@(posedge mclk);
		regRdStb <= 1'b0;
		#1;
		d = regRdData;
		@(posedge mclk);
		if (mask != 0)
			chk(d & mask, (a == 8'h1c ? cfgM : (a == 8'h20 ? preM : 16'h0)) & mask);
	endtask

	task automatic waitSck();
		logic p;
		p = sckOut;
		n = 0;
		while (sckOut === p)
			step();
	endtask

	function automatic logic [31:0] nextRnd(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// main sequence
	initial begin
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (3) @(posedge mclk);
		#1;
		chk({sckOe_n, wsOe_n, mclkOut, audioRunning, transmitDir}, 16'h19);
		rd(8'h1c, 16'hffff);
		rd(8'h20, 16'hffff);
		wr(8'h30, 16'hffff);
		rd(8'h30, 16'hffff);
		rd(8'h1c, 16'hffff);
		$display("test reset done");
		// random settings, always written while disabled
		repeat (16) begin
			lfsr = nextRnd(lfsr);
			d = lfsr[31:16];
			d[1] = d[1] | ~|d[7:1]; // divider never 0 or 1
			wr(8'h20, d);
			wr(8'h1c, lfsr[15:0] & 16'hfbff);
			rd(8'h1c, 16'hffff);
			rd(8'h20, 16'hffff);
		end
		for (int s = 0; s < 3; s++)
			for (int c = 0; c < 2; c++) begin
				wr(8'h1c, 16'(s * 2 + c));
				rd(8'h24, 16'h0);
				chk(d[2], 16'(s != 0 || c != 0));
			end
		wr(8'h1c, 16'h0600);
		repeat (3) @(posedge mclk);
		#1;
		chk({audioRunning, sckOe_n}, 16'h1);
		wr(8'h1c, 16'h0000);
		$display("test registers done");
		// master runs at three divider settings and framings
		for (int i = 0; i < 3; i++) begin
			wr(8'h20, 16'((i != 2) << 9 | odT[i] << 8 | ldT[i]));
			wr(8'h1c, 16'(16'h0a00 | i << 4 | (i & 1) << 3));
			wr(8'h1c, cfgM | 16'h0400);
			mTog = 0;
			waitSck();
			waitSck();
			chk(16'(n), 16'(2 * ldT[i] + odT[i]));
			chk({wsOut, channelSide}, i == 0 ? 16'h0 : 16'h2);
			chk({audioRunning, transmitDir, sckOe_n, wsOe_n}, 16'hc);
			chk(16'(mTog > 0), 16'(i != 2));
			wr(8'h1c, cfgM | 16'h0700);
			rd(8'h1c, 16'hffff);
			wr(8'h1c, cfgM & 16'hfbff);
			#1;
			chk({audioRunning, sckOe_n, wsOe_n, wsOut, sckOut}, 16'(12 + (i & 1)));
		end
		// frame sync length, short then long
		wr(8'h20, 16'h0002);
		for (int p = 0; p < 2; p++) begin
			wr(8'h1c, 16'(16'h0a30 | p << 7));
			wr(8'h1c, cfgM | 16'h0400);
			n = 0;
			while (wsOut !== 1'b1)
				step();
			n = 0;
			while (wsOut === 1'b1)
				step();
			chk(16'(n), p ? 16'h68 : 16'h8);
			wr(8'h1c, cfgM & 16'hfbff);
		end
		$display("test master done");
		// slave roles: clock and word select come from the far master
		wr(8'h20, 16'h0202);
		for (int j = 0; j < 3; j++) begin
			wr(8'h1c, 16'(16'h0800 | (j != 0) << 8 | (j == 2 ? 3 : j) << 4));
			wr(8'h1c, cfgM | 16'h0400);
			pRun <= 1'b1;
			n = 0;
			repeat (400) begin
				step();
				if (wsStab > 2)
					chk(channelSide, j == 0 ? wsQ : (j == 1 ? {~wsQ} : 1'b0));
			end
			chk({sckOe_n, wsOe_n, mclkOut, transmitDir}, j == 0 ? 16'hd : 16'hc);
			pRun <= 1'b0;
			wr(8'h1c, cfgM & 16'hfbff);
		end
		$display("test slave done");
		report_and_stop();
	end
endmodule // asc_mode_config_bench

`default_nettype wire
